// file: logic/sideband_pkg.sv
package sideband_pkg;
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned SYNC_STAGES      = 2;
  localparam logic [2:0]  FREQ_SEL_RESET   = 3'h0;
  localparam logic [31:0] RESET_VECTOR_DEF = 32'hFFFFFFF0;
  localparam int unsigned ADDR_WIDTH       = 32;
  localparam int unsigned ADDR_MASK_BIT    = 20;
  localparam int unsigned MON_WIDTH        = 4;
  // controller register offsets
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_STATUS       = 4'h1;
  localparam logic [3:0]  REG_FREQ         = 4'h2;
  localparam logic [3:0]  REG_MON          = 4'h3;
  // control field positions
  localparam int unsigned CTRL_MASK        = 0;
  localparam int unsigned CTRL_IGNORE      = 1;
  localparam int unsigned CTRL_INIT        = 2;
  localparam int unsigned CTRL_STOP        = 3;
  localparam int unsigned CTRL_IRQ0        = 4;
  localparam int unsigned CTRL_IRQ1        = 5;
  localparam int unsigned CTRL_PGOOD       = 6;
  localparam int unsigned CTRL_SMI         = 7;
  localparam int unsigned CTRL_DBG         = 8;
  localparam int unsigned CTRL_WIDTH       = 9;
  typedef enum logic [1:0] {
    CORE_RUN  = 2'b00,
    CORE_SMM  = 2'b01,
    CORE_HIZ  = 2'b11
  } core_state_e;
endpackage

// file: logic/sideband_if.sv
`timescale 1ns/1ps
interface sideband_if;
  logic       addr_bit_mask_in;
  logic       ignore_numeric_err;
  logic       soft_init;
  logic       stop_clock_req;
  logic       local_irq_pin0;
  logic       local_irq_pin1;
  logic       core_power_good;
  logic       sys_mgmt_irq;
  logic       debug_request;
  logic       io_target_ready;
  logic [2:0] clock_freq_select;
  logic       fp_error_break_o;
  logic       fp_error_break_oe_n;
  logic       debug_ready_o;
  logic       debug_ready_oe_n;
  logic [3:0] bkpt_perf_monitor_o;
  logic [3:0] bkpt_perf_monitor_oe_n;
  logic       sys_mgmt_ack;
  modport device (
    input  addr_bit_mask_in, ignore_numeric_err, soft_init, stop_clock_req,
    input  local_irq_pin0, local_irq_pin1, core_power_good, sys_mgmt_irq,
    input  debug_request, io_target_ready,
    output clock_freq_select, fp_error_break_o, fp_error_break_oe_n,
    output debug_ready_o, debug_ready_oe_n, bkpt_perf_monitor_o,
    output bkpt_perf_monitor_oe_n, sys_mgmt_ack
  );
  modport platform (
    output addr_bit_mask_in, ignore_numeric_err, soft_init, stop_clock_req,
    output local_irq_pin0, local_irq_pin1, core_power_good, sys_mgmt_irq,
    output debug_request, io_target_ready,
    input  clock_freq_select, fp_error_break_o, fp_error_break_oe_n,
    input  debug_ready_o, debug_ready_oe_n, bkpt_perf_monitor_o,
    input  bkpt_perf_monitor_oe_n, sys_mgmt_ack
  );
endinterface

// file: logic/sideband_device.sv
`timescale 1ns/1ps
module sideband_device
  import sideband_pkg::*;
#(
  parameter int unsigned ADDR_W = ADDR_WIDTH,
  parameter logic [2:0]  FREQ_SEL = FREQ_SEL_RESET
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // platform side
  sideband_if.device                 link,
  // core side
  input  wire logic [ADDR_W-1:0]     core_addr,
  output logic      [ADDR_W-1:0]     bus_addr,
  input  wire logic                  fp_error_event,
  input  wire logic                  fp_error_masked,
  input  wire logic                  fp_noncontrol_issue,
  output logic                       fp_exception,
  output logic                       fp_pending_error,
  input  wire logic                  numeric_error_enable,
  input  wire logic                  apic_disable,
  output logic                       maskable_irq_req,
  output logic                       nmi_req,
  output logic                       local_irq0_out,
  output logic                       local_irq1_out,
  output logic                       int_regs_reset,
  output logic                       fetch_restart,
  output logic      [31:0]           fetch_vector,
  input  wire logic                  snoop_req,
  output logic                       snoop_ack,
  output logic                       sys_mgmt_mode,
  output logic                       state_save,
  output logic                       outputs_float,
  input  wire logic [MON_WIDTH-1:0]  monitor_status,
  input  wire logic [31:0]           reset_vector_cfg
);
  initial begin
    if (ADDR_W <= ADDR_MASK_BIT) $error("address too narrow");
  end

  localparam int unsigned NSYNC = 9;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_q;
  assign async_in = {link.io_target_ready, link.debug_request, link.sys_mgmt_irq,
                     link.core_power_good, link.local_irq_pin1, link.local_irq_pin0,
                     link.stop_clock_req, link.soft_init,
                     link.addr_bit_mask_in};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_q <= '0;
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
      sync_q <= sync_b;   // extra stage for edge detection on clean copies
    end
  end

  logic ign_a, ign_b;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ign_a <= 1'b0;
      ign_b <= 1'b0;
    end else begin
      ign_a <= link.ignore_numeric_err;
      ign_b <= ign_a;
    end
  end

  logic mask_s, init_s, stop_s, irq0_s, irq1_s, pgood_s, smi_s, dbg_s;
  assign mask_s  = sync_b[0];
  assign init_s  = sync_b[1];
  assign stop_s  = sync_b[2];
  assign irq0_s  = sync_b[3];
  assign irq1_s  = sync_b[4];
  assign pgood_s = sync_b[5];
  assign smi_s   = sync_b[6];
  assign dbg_s   = sync_b[7];

  // address masking, registered so the output comes from a flop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_addr <= '0;
    end else begin
      bus_addr <= core_addr;
      if (mask_s) begin
        bus_addr[ADDR_MASK_BIT] <= 1'b0;
      end
    end
  end

  // pending numeric error; set wins over clear
  logic pend;
  always_ff @(posedge clk_sys) begin
    if (reset || !pgood_s) begin
      pend <= 1'b0;
    end else if (fp_error_event && !fp_error_masked) begin
      pend <= 1'b1;
    end else if (fp_noncontrol_issue && pend && (numeric_error_enable || !ign_b)) begin
      pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fp_exception     <= 1'b0;
      fp_pending_error <= 1'b0;
    end else begin
      // ignore only matters while the enable bit is clear
      fp_exception     <= fp_noncontrol_issue && pend
                          && (numeric_error_enable || !ign_b);
      fp_pending_error <= pend;
    end
  end

  // error / break pin: open drain, oe_n low drives it low (asserted)
  logic brk;
  always_ff @(posedge clk_sys) begin
    if (reset || !stop_s) begin
      brk <= 1'b0;
    end else if (dbg_s && !sync_q[7]) begin
      brk <= 1'b1;
    end else if (stop_s && !sync_q[2]) begin
      brk <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link.fp_error_break_o    <= 1'b0;
      link.fp_error_break_oe_n <= 1'b1;
    end else begin
      link.fp_error_break_o    <= 1'b0;
      // the first stop cycle is covered before brk sets, so the pin never blinks
      link.fp_error_break_oe_n <= !(stop_s ? (brk || !sync_q[2]) : pend)
                                  || outputs_float;
    end
  end

  // local interrupt pins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      maskable_irq_req <= 1'b0;
      nmi_req          <= 1'b0;
      local_irq0_out   <= 1'b0;
      local_irq1_out   <= 1'b0;
    end else begin
      // apic_disable low after reset keeps the pins as local lines
      maskable_irq_req <= apic_disable && irq0_s;
      nmi_req          <= apic_disable && irq1_s;
      local_irq0_out   <= !apic_disable && irq0_s;
      local_irq1_out   <= !apic_disable && irq1_s;
    end
  end

  // soft init: integer state only, then restart fetch
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      int_regs_reset <= 1'b0;
      fetch_restart  <= 1'b0;
      fetch_vector   <= RESET_VECTOR_DEF;
    end else begin
      int_regs_reset <= init_s;
      fetch_restart  <= !init_s && sync_q[1];
      if (!init_s && sync_q[1]) begin
        fetch_vector <= reset_vector_cfg;
      end
    end
  end

  // snoops never blocked by soft init
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      snoop_ack <= 1'b0;
    end else begin
      snoop_ack <= snoop_req;
    end
  end

  // system management
  core_state_e state;
  logic        smi_release;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      smi_release <= 1'b1;
    end else begin
      smi_release <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= CORE_RUN;
    end else begin
      unique case (state)
        CORE_RUN: begin
          if (smi_release && link.sys_mgmt_irq) begin
            state <= CORE_HIZ;
          end else if (smi_s && pgood_s) begin
            state <= CORE_SMM;
          end
        end
        CORE_SMM: begin
          if (!smi_s) begin
            state <= CORE_RUN;
          end
        end
        CORE_HIZ: begin
          state <= CORE_HIZ;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sys_mgmt_mode     <= 1'b0;
      state_save        <= 1'b0;
      link.sys_mgmt_ack <= 1'b0;
      outputs_float     <= 1'b0;
    end else begin
      state_save        <= (state == CORE_RUN) && smi_s && pgood_s && !smi_release;
      link.sys_mgmt_ack <= state_save;
      sys_mgmt_mode     <= (state == CORE_SMM);
      outputs_float     <= (state == CORE_HIZ);
    end
  end

  // frequency select and debug handshake
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link.clock_freq_select      <= FREQ_SEL_RESET;
      link.debug_ready_o          <= 1'b0;
      link.debug_ready_oe_n       <= 1'b1;
      link.bkpt_perf_monitor_o    <= '0;
      link.bkpt_perf_monitor_oe_n <= '1;
    end else begin
      link.clock_freq_select      <= FREQ_SEL;
      link.debug_ready_o          <= 1'b0;
      link.debug_ready_oe_n       <= !(dbg_s && !stop_s) || outputs_float;
      link.bkpt_perf_monitor_o    <= '0;
      link.bkpt_perf_monitor_oe_n <= ~monitor_status | {MON_WIDTH{outputs_float}};
    end
  end
  // deep sleep requests have no input here: unsupported
endmodule

// file: logic/sideband_platform.sv
`timescale 1ns/1ps
module sideband_platform
  import sideband_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  // software port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [31:0]          reg_rdata,
  // device side
  sideband_if.platform              link
);
  logic [CTRL_WIDTH-1:0] ctrl;
  logic                  brk_seen;
  logic                  ack_seen;

  // control bits drive the pins from flops; power good low after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl <= '0;
    end else if (reg_write && reg_addr == REG_CTRL) begin
      ctrl <= reg_wdata[CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link.addr_bit_mask_in   <= 1'b0;
      link.ignore_numeric_err <= 1'b0;
      link.soft_init          <= 1'b0;
      link.stop_clock_req     <= 1'b0;
      link.local_irq_pin0     <= 1'b0;
      link.local_irq_pin1     <= 1'b0;
      link.core_power_good    <= 1'b0;
      link.sys_mgmt_irq       <= 1'b0;
      link.debug_request      <= 1'b0;
      link.io_target_ready    <= 1'b0;
    end else begin
      // target ready pulses the cycle before the sideband levels change
      link.addr_bit_mask_in   <= ctrl[CTRL_MASK];
      link.ignore_numeric_err <= ctrl[CTRL_IGNORE];
      link.soft_init          <= ctrl[CTRL_INIT];
      link.stop_clock_req     <= ctrl[CTRL_STOP];
      link.local_irq_pin0     <= ctrl[CTRL_IRQ0];
      link.local_irq_pin1     <= ctrl[CTRL_IRQ1];
      link.core_power_good    <= ctrl[CTRL_PGOOD];
      link.sys_mgmt_irq       <= ctrl[CTRL_SMI];
      link.debug_request      <= ctrl[CTRL_DBG];
      link.io_target_ready    <= reg_write && reg_addr == REG_CTRL;
    end
  end

  // sticky status; a new event wins over the clear-on-read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      brk_seen <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      brk_seen <= !link.fp_error_break_oe_n
                  || (brk_seen && !(reg_read && reg_addr == REG_STATUS));
      ack_seen <= link.sys_mgmt_ack
                  || (ack_seen && !(reg_read && reg_addr == REG_STATUS));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      unique case (reg_addr)
        REG_CTRL:   reg_rdata <= 32'(ctrl);
        REG_STATUS: reg_rdata <= {28'h0, !link.debug_ready_oe_n, ack_seen,
                                  !link.fp_error_break_oe_n, brk_seen};
        REG_FREQ:   reg_rdata <= {29'h0, link.clock_freq_select};
        REG_MON:    reg_rdata <= {28'h0, ~link.bkpt_perf_monitor_oe_n};
        default:    reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule

// file: bench/sideband_checker.sv
`timescale 1ns/1ps
module sideband_checker
  import sideband_pkg::*;
#(
  parameter logic [2:0] FREQ_SEL = FREQ_SEL_RESET
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // platform drives
  input wire logic       stop_clock_req,
  input wire logic       core_power_good,
  input wire logic       sys_mgmt_irq,
  input wire logic       debug_request,
  // device drives
  input wire logic [2:0] clock_freq_select,
  input wire logic       fp_error_break_o,
  input wire logic       fp_error_break_oe_n,
  input wire logic       debug_ready_o,
  input wire logic       debug_ready_oe_n,
  input wire logic [3:0] bkpt_perf_monitor_o,
  input wire logic       sys_mgmt_ack
);
  logic [3:0] mgmt_age;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // saturating age, so a stale request cannot excuse a late acknowledge
  always_ff @(posedge clk_sys) begin
    if (reset || sys_mgmt_irq) begin
      mgmt_age <= 4'h0;
    end else if (mgmt_age != 4'hF) begin
      mgmt_age <= mgmt_age + 4'h1;
    end
  end
  property p_brk_stop;
    $rose(stop_clock_req) |-> ##[2:4] !fp_error_break_oe_n;
  endproperty
  a_brk_stop: assert property (p_brk_stop) else $error("break late after stop");
  property p_brk_hold;
    stop_clock_req [*5] |-> !fp_error_break_oe_n;
  endproperty
  a_brk_hold: assert property (p_brk_hold) else $error("break dropped under stop");
  property p_sync_lag;
    $rose(stop_clock_req) && fp_error_break_oe_n |=> fp_error_break_oe_n;
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("stop acted on unsynchronised");
  property p_dbg_break;
    (debug_request && stop_clock_req) [*5] |-> !fp_error_break_oe_n && debug_ready_oe_n;
  endproperty
  a_dbg_break: assert property (p_dbg_break) else $error("debug under stop wrong");
  property p_dbg_ready;
    (debug_request && !stop_clock_req) [*5] |-> !debug_ready_oe_n;
  endproperty
  a_dbg_ready: assert property (p_dbg_ready) else $error("debug ready missing");
  property p_dbg_idle;
    !debug_request [*5] |-> debug_ready_oe_n;
  endproperty
  a_dbg_idle: assert property (p_dbg_idle) else $error("debug ready without request");
  property p_ack;
    $rose(sys_mgmt_irq) && core_power_good && $past(core_power_good, 3) |-> ##[2:5] sys_mgmt_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("mgmt acknowledge missing");
  property p_ack_cause;
    sys_mgmt_ack |-> mgmt_age <= 4'h6 ##1 !sys_mgmt_ack;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("acknowledge uncaused or long");
  property p_freq;
    clock_freq_select == FREQ_SEL;
  endproperty
  a_freq: assert property (p_freq) else $error("frequency select wrong");
  property p_od_low;
    !fp_error_break_o && !debug_ready_o && bkpt_perf_monitor_o == 4'h0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drives high");
endmodule

// file: bench/test_legacy_sideband_signals.sv
`timescale 1ns/1ps
module test_legacy_sideband_signals;
  import sideband_pkg::*;
  localparam logic [31:0] PG = 32'h1 << CTRL_PGOOD;
  localparam logic [31:0] STP = 32'h1 << CTRL_STOP;
  localparam logic [31:0] DBG = 32'h1 << CTRL_DBG;
  localparam logic [31:0] MGI = 32'h1 << CTRL_SMI;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata, bus_addr, fetch_vector;
  logic [31:0] core_addr = 32'h0;
  logic [31:0] vec_cfg = 32'h0;
  logic [31:0] lfsr = 32'h0B7D;
  logic        fp_ev = 1'b0, fp_msk = 1'b0, fp_iss = 1'b0, err_en = 1'b0;
  logic        apic_dis = 1'b0, snoop = 1'b0;
  logic [3:0]  mon = 4'h0;
  logic        fp_exc, fp_pend, mirq, nmi, lirq0, lirq1, int_rst, snoop_ack, mgmt_mode;
  logic        fetch_rst, save, outs_float;
  int          n_exc = 0;
  int          n_restart = 0;
  int          n_save = 0;
  int          n_fail = 0;
  int          samples_checked = 0;
  sideband_if link ();
  sideband_device u_sideband_device (.clk_sys(clk_sys), .reset(reset), .link(link),
    .core_addr(core_addr), .bus_addr(bus_addr), .fp_error_event(fp_ev),
    .fp_error_masked(fp_msk), .fp_noncontrol_issue(fp_iss), .fp_exception(fp_exc),
    .fp_pending_error(fp_pend), .numeric_error_enable(err_en), .apic_disable(apic_dis),
    .maskable_irq_req(mirq), .nmi_req(nmi), .local_irq0_out(lirq0), .local_irq1_out(lirq1),
    .int_regs_reset(int_rst), .fetch_restart(fetch_rst), .fetch_vector(fetch_vector),
    .snoop_req(snoop), .snoop_ack(snoop_ack), .sys_mgmt_mode(mgmt_mode), .state_save(save),
    .outputs_float(outs_float), .monitor_status(mon), .reset_vector_cfg(vec_cfg));
  sideband_platform u_sideband_platform (.clk_sys(clk_sys), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .link(link));
  sideband_checker #(.FREQ_SEL(FREQ_SEL_RESET)) u_sideband_checker (.clk_sys(clk_sys),
    .reset(reset), .stop_clock_req(link.stop_clock_req),
    .core_power_good(link.core_power_good), .sys_mgmt_irq(link.sys_mgmt_irq),
    .debug_request(link.debug_request), .clock_freq_select(link.clock_freq_select),
    .fp_error_break_o(link.fp_error_break_o), .fp_error_break_oe_n(link.fp_error_break_oe_n),
    .debug_ready_o(link.debug_ready_o), .debug_ready_oe_n(link.debug_ready_oe_n),
    .bkpt_perf_monitor_o(link.bkpt_perf_monitor_o), .sys_mgmt_ack(link.sys_mgmt_ack));
  always #12.5 clk_sys = ~clk_sys;
  // one-cycle pulses are counted here, so a check may look later
  always @(posedge clk_sys) begin
    if (fp_exc === 1'b1) n_exc <= n_exc + 1;
    if (fetch_rst === 1'b1) n_restart <= n_restart + 1;
    if (save === 1'b1) n_save <= n_save + 1;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // a write, then the settle time of two sync flops, the edge flop and the output flop
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // the tests need about 350 cycles; over fifty times that means a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
  initial begin
    logic [31:0] d;
    int          base;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      core_addr <= lfsr;
      apic_dis <= lfsr[3];
      wr(REG_CTRL, PG | 32'(lfsr[0]) << CTRL_MASK | 32'(lfsr[1]) << CTRL_IRQ0
         | 32'(lfsr[2]) << CTRL_IRQ1);
      chk("bus_addr", lfsr[0] ? lfsr & ~(32'h1 << ADDR_MASK_BIT) : lfsr, bus_addr);
      chk("maskable", 32'(lfsr[3] & lfsr[1]), 32'(mirq));
      chk("nmi", 32'(lfsr[3] & lfsr[2]), 32'(nmi));
      chk("local0", 32'(!lfsr[3] & lfsr[1]), 32'(lirq0));
      chk("local1", 32'(!lfsr[3] & lfsr[2]), 32'(lirq1));
    end
    $display("pin routing test done");
    vec_cfg <= lfsr;
    snoop <= 1'b1;
    wr(REG_CTRL, PG | 32'h1 << CTRL_INIT);
    chk("int_reset", 32'h1, 32'(int_rst));
    chk("snoop_ack", 32'h1, 32'(snoop_ack));
    wr(REG_CTRL, PG);
    chk("int_reset", 32'h0, 32'(int_rst));
    chk("fetch_vector", vec_cfg, fetch_vector);
    chk("fetch_restart", 32'h1, 32'(n_restart));
    $display("soft init test done");
    for (int k = 0; k < 3; k++) begin
      err_en <= (k == 1);
      base = n_exc;
      wr(REG_CTRL, PG | 32'(k < 2) << CTRL_IGNORE);
      @(posedge clk_sys);
      fp_ev <= 1'b1;
      @(posedge clk_sys);
      fp_ev <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk("fp_pending", 32'h1, 32'(fp_pend));
      chk("fp_pin", 32'h0, 32'(link.fp_error_break_oe_n));
      fp_iss <= 1'b1;
      @(posedge clk_sys);
      fp_iss <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk("fp_exception", 32'(k > 0), 32'(n_exc - base));
      chk("fp_pin_after", 32'(k > 0), 32'(link.fp_error_break_oe_n));
    end
    $display("numeric error test done");
    mon <= lfsr[3:0];
    wr(REG_CTRL, PG | STP);
    chk("break", 32'h0, 32'(link.fp_error_break_oe_n));
    rd(REG_STATUS, d);
    chk("status_break", 32'h1, 32'(d[1]));
    wr(REG_CTRL, PG | STP | DBG);
    chk("break_debug", 32'h0, 32'(link.fp_error_break_oe_n));
    chk("ready_under_stop", 32'h1, 32'(link.debug_ready_oe_n));
    wr(REG_CTRL, PG | DBG);
    chk("break_released", 32'h1, 32'(link.fp_error_break_oe_n));
    chk("debug_ready", 32'h0, 32'(link.debug_ready_oe_n));
    chk("monitor", {28'h0, ~mon}, 32'(link.bkpt_perf_monitor_oe_n));
    $display("stop and debug test done");
    wr(REG_CTRL, MGI);
    chk("mgmt_refused", 32'h0, 32'(mgmt_mode));
    wr(REG_CTRL, PG);
    wr(REG_CTRL, PG | MGI);
    chk("mgmt_mode", 32'h1, 32'(mgmt_mode));
    rd(REG_STATUS, d);
    chk("status_ack", 32'h1, 32'(d[2]));
    chk("state_save", 32'h1, 32'(n_save));
    chk("outputs_float", 32'h0, 32'(outs_float));
    rd(REG_FREQ, d);
    chk("freq_reg", 32'(FREQ_SEL_RESET), d);
    rd(4'hF, d);
    chk("unmapped", 32'h0, d);
    $display("management and register test done");
    give_verdict();
  end
endmodule
